// [rtl/flash_cmd_regs.svh]
// Constants for the flash command and status logic: offsets, codes, timing.
// Assumes a 16-bit CPU address bus, byte data and a 40 MHz sys_clk.
// Behaviour
// - ID mode returns vendor, flash, security codes
// - Exit command leaves ID mode
// - Protection blocks parallel-mode array read/write
// - Protection rejects serial overwrite and RAM loader
// - Only full erase clears protection
// - Protection set within 40 us, blocks commands
// - Bit 6 inverts each array read while busy with commands enabled
// - First read after launch shows toggle 1
// - Disabled command field stops toggling
// - Array access blocked while operation runs
// - Byte write, 4 KB sector or full erase
// - Reads single access, writes multi-cycle commands
// - RAM loader masks irqs, sets vector bit
// - Any NMI causes a system clock reset
// - Low-speed byte write shows no toggle
// - AA,55,90 at unlock addresses enter ID
// - Full erase within 30 ms, all 0xFF
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MODE_AREA_ADDR 16'h0FD0
`define COMMIT_ADDR 16'h0FD1
`define SYS_CTRL_C_ADDR 16'h0FD2
`define STATUS_ADDR 16'h0FD3

// ****************************************
// Fields and keys
// ****************************************
`define CMD_EN_LSB 5
`define CMD_EN_ON 3'h5
`define CMD_EN_OFF 3'h2
`define COMMIT_KEY 8'hD5
`define MODE_AREA_RESET 8'h40
`define VEC_LOC_BIT 0
`define IRQ_MASK_BIT 1

// ****************************************
// Command sequence codes
// ****************************************
`define LOW_UNLOCK 12'h555
`define HIGH_UNLOCK 12'hAAA
`define KEY_FIRST 8'hAA
`define KEY_SECOND 8'h55
`define OP_PROGRAM 8'hA0
`define OP_ERASE 8'h80
`define OP_ID_ENTRY 8'h90
`define OP_SECURE 8'hA5
`define OP_ID_EXIT 8'hF0
`define OP_CHIP 8'h10
`define OP_SECTOR 8'h30
`define SECURE_ADDR 16'hFF7F
`define ID_VENDOR_ADDR 16'hF000
`define ID_FLASH_ADDR 16'hF001
`define ERASED_BYTE 8'hFF
`define ARRAY_BASE_NIB 4'hC

// ****************************************
// Timing at 40 MHz
// ****************************************
`define CLK_MHZ 40
`define PROG_US 40
`define SECURE_US 40
`define ERASE_MS 30
`define PROG_CYCLES (`PROG_US * `CLK_MHZ)
`define SECURE_CYCLES (`SECURE_US * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_MS * 1000 * `CLK_MHZ)
`define SLOW_CYCLES 1

`endif

// [rtl/flash_cmd_pkg.sv]
// Types shared by the flash command and status logic.
// Assumes the constants header is included by each user.
package flash_cmd_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_KEY1 = 4'h1,
    SEQ_KEY2 = 4'h3,
    SEQ_ERASE = 4'h2,
    SEQ_EKEY1 = 4'h6,
    SEQ_EKEY2 = 4'h7,
    SEQ_PROG = 4'h5,
    SEQ_SECURE = 4'h4,
    SEQ_BUSY = 4'hC
  } seq_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_BYTE = 2'h1,
    OP_FULL = 2'h3,
    OP_PROT = 2'h2
  } op_kind_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic wr;
    logic rd;
  } cpu_bus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic wr;
    logic sector;
    logic chip;
  } array_cmd_t;
endpackage

// [rtl/op_timer.sv]
// Busy timer for one launched array operation.
// Assumes start is a one-cycle pulse and cycles is held stable meanwhile.
`timescale 1ns/1ps
module op_timer
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [20:0] cycles,
  output logic busy
);
  logic [20:0] count;
  logic [20:0] next_count;

  always_comb begin
    next_count = count;
    if (start) begin
      next_count = cycles;
    end else if (count != 21'h0) begin
      next_count = count - 21'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= 21'h0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != 21'h0);
endmodule

// [rtl/flash_array.sv]
// Byte-wide flash array of 16 KB with 4 KB sector and full erase.
// Assumes at most one write or erase command per cycle.
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module flash_array
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire array_cmd_t cmd,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:16383];
  logic [7:0] next_rd;

  always_comb begin
    next_rd = mem[rd_addr[13:0]];
  end

  // Erase is slow in silicon but modelled at once; the busy timer hides it
  always_ff @(posedge sys_clk) begin
    if (cmd.chip) begin
      for (int i = 0; i < 16384; i++) begin
        mem[i] <= `ERASED_BYTE;
      end
    end else if (cmd.sector) begin
      for (int i = 0; i < 4096; i++) begin
        mem[{cmd.addr[13:12], 12'h000} + i[13:0]] <= `ERASED_BYTE;
      end
    end else if (cmd.wr) begin
      mem[cmd.addr[13:0]] <= cmd.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd;
    end
  end
endmodule

// [rtl/flash_cmd_ctrl.sv]
// Command sequencer, ID mode, protection and toggle-bit status of the flash.
// Assumes the CPU issues single-cycle byte strobes, never read and write together.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module flash_cmd_ctrl
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire cpu_bus_t bus,
  input wire logic parallel_mode,
  input wire logic serial_mode,
  input wire logic slow_mode,
  input wire logic loader_entry,
  input wire logic overwrite_req,
  input wire logic loader_req,
  input wire logic software_irq,
  input wire logic undefined_instr_irq,
  input wire logic watchdog_irq,
  output logic [7:0] rd_data,
  output logic busy,
  output logic access_block,
  output logic protected_out,
  output logic overwrite_ok,
  output logic loader_ok,
  output logic irq_masked,
  output logic clock_reset
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic unlock_at(input logic [15:0] a, input logic [11:0] lo);
    unlock_at = (a[15:14] == 2'b11) && (a[11:0] == lo);
  endfunction

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a[15:12] >= `ARRAY_BASE_NIB);
  endfunction

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] flash_mode_area_reg;
  logic [7:0] next_mode_area;
  logic [2:0] command_enable_field;
  logic [2:0] next_cmd_en;
  logic [1:0] system_ctrl_reg_c;
  logic [1:0] next_sys_c;
  logic cmd_on;

  always_comb begin
    next_mode_area = flash_mode_area_reg;
    next_cmd_en = command_enable_field;
    next_sys_c = system_ctrl_reg_c;
    if (bus.wr && bus.addr == `MODE_AREA_ADDR) begin
      next_mode_area = bus.data;
    end
    // Settings act only after the commit key
    if (bus.wr && bus.addr == `COMMIT_ADDR && bus.data == `COMMIT_KEY) begin
      next_cmd_en = flash_mode_area_reg[`CMD_EN_LSB +: 3];
    end
    if (bus.wr && bus.addr == `SYS_CTRL_C_ADDR) begin
      next_sys_c = bus.data[1:0];
    end
    // Loader entry masks irqs and moves vectors to RAM
    if (loader_entry) begin
      next_sys_c = 2'h3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_mode_area_reg <= `MODE_AREA_RESET;
      command_enable_field <= `CMD_EN_OFF;
      system_ctrl_reg_c <= 2'h0;
    end else begin
      flash_mode_area_reg <= next_mode_area;
      command_enable_field <= next_cmd_en;
      system_ctrl_reg_c <= next_sys_c;
    end
  end

  assign cmd_on = (command_enable_field == `CMD_EN_ON);
  assign irq_masked = system_ctrl_reg_c[`IRQ_MASK_BIT];
  // Any non-maskable event resets the system clock
  assign clock_reset = software_irq | undefined_instr_irq | watchdog_irq;

  // ****************************************
  // Command sequencer
  // ****************************************
  seq_state_t state;
  seq_state_t next_state;
  op_kind_t op;
  op_kind_t next_op;
  logic id_mode;
  logic next_id_mode;
  logic prot;
  logic next_prot;
  logic start;
  logic [20:0] start_cycles;
  array_cmd_t acmd;
  logic [15:0] rd_addr_q;
  logic [7:0] array_byte;

  always_comb begin
    next_state = state;
    next_op = op;
    next_id_mode = id_mode;
    next_prot = prot;
    start = 1'b0;
    start_cycles = 21'h0;
    acmd = '0;
    // Exit command at any address, even mid-sequence
    if (bus.wr && bus.data == `OP_ID_EXIT && state != SEQ_BUSY) begin
      next_id_mode = 1'b0;
      next_state = SEQ_IDLE;
    end else if (bus.wr) begin
      unique case (state)
        SEQ_IDLE: begin
          if (unlock_at(bus.addr, `LOW_UNLOCK) && bus.data == `KEY_FIRST) begin
            next_state = SEQ_KEY1;
          end
        end
        SEQ_KEY1: begin
          next_state = (unlock_at(bus.addr, `HIGH_UNLOCK) && bus.data == `KEY_SECOND)
                       ? SEQ_KEY2 : SEQ_IDLE;
        end
        SEQ_KEY2: begin
          next_state = SEQ_IDLE;
          if (unlock_at(bus.addr, `LOW_UNLOCK)) begin
            if (bus.data == `OP_ID_ENTRY) begin
              next_id_mode = 1'b1;
            end else if (bus.data == `OP_PROGRAM && cmd_on) begin
              next_state = SEQ_PROG;
            end else if (bus.data == `OP_ERASE && cmd_on) begin
              next_state = SEQ_ERASE;
            end else if (bus.data == `OP_SECURE && cmd_on) begin
              next_state = SEQ_SECURE;
            end
          end
        end
        SEQ_ERASE: begin
          next_state = (unlock_at(bus.addr, `LOW_UNLOCK) && bus.data == `KEY_FIRST)
                       ? SEQ_EKEY1 : SEQ_IDLE;
        end
        SEQ_EKEY1: begin
          next_state = (unlock_at(bus.addr, `HIGH_UNLOCK) && bus.data == `KEY_SECOND)
                       ? SEQ_EKEY2 : SEQ_IDLE;
        end
        SEQ_EKEY2: begin
          next_state = SEQ_IDLE;
          if (unlock_at(bus.addr, `LOW_UNLOCK) && bus.data == `OP_CHIP) begin
            acmd.chip = 1'b1;
            next_prot = 1'b0;
            next_op = OP_FULL;
            start = 1'b1;
            start_cycles = 21'(`ERASE_CYCLES);
            next_state = SEQ_BUSY;
          end else if (in_array(bus.addr) && bus.data == `OP_SECTOR && !parallel_mode) begin
            acmd.sector = 1'b1;
            acmd.addr = bus.addr;
            next_op = OP_FULL;
            start = 1'b1;
            start_cycles = 21'(`ERASE_CYCLES);
            next_state = SEQ_BUSY;
          end
        end
        SEQ_PROG: begin
          next_state = SEQ_IDLE;
          // Parallel-mode write refused while protected
          if (in_array(bus.addr) && !(prot && parallel_mode)) begin
            acmd.wr = 1'b1;
            acmd.addr = bus.addr;
            acmd.data = bus.data;
            next_op = OP_BYTE;
            start = 1'b1;
            start_cycles = slow_mode ? 21'(`SLOW_CYCLES) : 21'(`PROG_CYCLES);
            next_state = SEQ_BUSY;
          end
        end
        SEQ_SECURE: begin
          next_state = SEQ_IDLE;
          if (bus.addr == `SECURE_ADDR && bus.data == 8'h00) begin
            next_prot = 1'b1;
            next_op = OP_PROT;
            start = 1'b1;
            start_cycles = 21'(`SECURE_CYCLES);
            next_state = SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          next_state = SEQ_BUSY;
        end
        default: begin
          next_state = SEQ_IDLE;
        end
      endcase
    end
    if (state == SEQ_BUSY && !busy) begin
      next_state = SEQ_IDLE;
      next_op = OP_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SEQ_IDLE;
      op <= OP_NONE;
      id_mode <= 1'b0;
      prot <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      id_mode <= next_id_mode;
      prot <= next_prot;
    end
  end

  op_timer timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(start),
    .cycles(start_cycles),
    .busy(busy)
  );

  flash_array array (
    .sys_clk(sys_clk),
    .rst(rst),
    .cmd(acmd),
    .rd_addr(bus.addr),
    .rd_data(array_byte)
  );

  assign access_block = busy;
  assign protected_out = prot;
  assign overwrite_ok = serial_mode && overwrite_req && !prot;
  assign loader_ok = serial_mode && loader_req && !prot;

  // ****************************************
  // Read path and toggle bit
  // ****************************************
  logic toggle_bit;
  logic next_toggle;
  logic [7:0] next_rd_data;
  logic rd_q;
  logic [1:0] rd_sel;
  logic [11:0] prot_wait;
  logic [11:0] next_prot_wait;

  always_comb begin
    next_toggle = toggle_bit;
    // Flip after each answer, so the primed 1 is what the first read shows
    if (start) begin
      next_toggle = 1'b1;
    end else if (rd_q && busy && cmd_on && in_array(rd_addr_q)) begin
      next_toggle = ~toggle_bit;
    end
    next_prot_wait = (start && next_op == OP_PROT) ? 12'h001
                     : (busy && prot_wait != 12'h000) ? prot_wait + 12'h001 : 12'h000;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      toggle_bit <= 1'b0;
      rd_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      prot_wait <= 12'h000;
    end else begin
      toggle_bit <= next_toggle;
      prot_wait <= next_prot_wait;
      rd_q <= bus.rd;
      rd_addr_q <= bus.addr;
    end
  end

  always_comb begin
    rd_sel = 2'h0;
    next_rd_data = 8'h00;
    if (rd_q) begin
      if (rd_addr_q == `MODE_AREA_ADDR) begin
        next_rd_data = flash_mode_area_reg;
      end else if (rd_addr_q == `SYS_CTRL_C_ADDR) begin
        next_rd_data = {6'h00, system_ctrl_reg_c};
      end else if (rd_addr_q == `STATUS_ADDR) begin
        next_rd_data = {3'h0, command_enable_field, prot, busy};
      end else if (in_array(rd_addr_q)) begin
        rd_sel = 2'h1;
      end
    end
    if (rd_sel == 2'h1) begin
      if (busy) begin
        next_rd_data = {1'b0, toggle_bit, 6'h00};
      end else if (id_mode && rd_addr_q == `ID_VENDOR_ADDR) begin
        next_rd_data = 8'h11; // Arbitrary vendor code
      end else if (id_mode && rd_addr_q == `ID_FLASH_ADDR) begin
        next_rd_data = 8'h22; // Arbitrary flash code
      end else if (id_mode && rd_addr_q == `SECURE_ADDR) begin
        next_rd_data = prot ? 8'h00 : 8'hFF;
      end else if (!(prot && parallel_mode)) begin
        next_rd_data = array_byte;
      end
    end
  end

  assign rd_data = next_rd_data;

  // ****************************************
  // Checks
  // ****************************************
  a_toggle_first: assert property (@(posedge sys_clk) disable iff (rst)
    start |=> toggle_bit) else $error("toggle not primed");
  a_toggle_flip: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && busy && cmd_on && in_array(rd_addr_q) && !start) |=> toggle_bit != $past(toggle_bit))
    else $error("toggle did not invert");
  a_toggle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!cmd_on && !start) |=> toggle_bit == $past(toggle_bit))
    else $error("toggle moved while disabled");
  a_secure_busy: assert property (@(posedge sys_clk) disable iff (rst)
    (start && next_op == OP_PROT) |=> busy [*8]) else $error("protection ended early");
  a_secure_time: assert property (@(posedge sys_clk) disable iff (rst)
    (prot_wait > 12'(`SECURE_CYCLES)) |-> !busy) else $error("protection took too long");
  a_prot_clear: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(prot)) |-> $past(acmd.chip)) else $error("protection cleared wrongly");
  a_block_read: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && busy && in_array(rd_addr_q)) |-> rd_data[5:0] == 6'h00)
    else $error("array read while busy");
  a_id_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (bus.wr && bus.data == `OP_ID_EXIT && state != SEQ_BUSY) |=> !id_mode)
    else $error("id mode not left");
  a_bad_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    (state == SEQ_KEY1 && bus.wr && bus.data != `KEY_SECOND) |=> state == SEQ_IDLE)
    else $error("bad cycle kept sequence");
  a_serial_lock: assert property (@(posedge sys_clk) disable iff (rst)
    prot |-> !overwrite_ok && !loader_ok) else $error("serial command not refused");
  a_nmi_reset: assert property (@(posedge sys_clk) disable iff (rst)
    watchdog_irq |-> clock_reset) else $error("no clock reset on nmi");
endmodule

// [sim/cpu_model.sv]
// Behavioural CPU core issuing byte bus cycles to the flash command logic.
// Assumes rdata is the read answer, valid only in the cycle after a read strobe.
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module cpu_model
  import flash_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output cpu_bus_t bus
);
  initial bus = '0;

  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic drive(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge sys_clk);
    bus <= {a, d, w, r};
  endtask

  // Released lines show inverted values, so nothing stale passes as valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    drive(a, d, 1'b1, 1'b0);
    drive(~a, ~d, 1'b0, 1'b0);
  endtask

  // Byte reads only: a wide transfer breaks the toggle bit
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    drive(a, 8'h00, 1'b0, 1'b1);
    drive(~a, 8'hFF, 1'b0, 1'b0);
    #1;
    v = rdata;
  endtask

  task automatic cmd(input logic [7:0] op);
    wr(16'hF555, `KEY_FIRST);
    wr(16'hFAAA, `KEY_SECOND);
    wr(16'hF555, op);
  endtask

  task automatic cmd_on();
    wr(`MODE_AREA_ADDR, 8'hA0);
    wr(`COMMIT_ADDR, `COMMIT_KEY);
  endtask

  task automatic cmd_off();
    wr(`MODE_AREA_ADDR, 8'h40);
    wr(`COMMIT_ADDR, `COMMIT_KEY);
  endtask

  // Two reads in a row until they agree; bounded so a stuck toggle cannot hang
  task automatic poll(input logic [15:0] a, output logic [7:0] v, output logic ok);
    logic [7:0] p;
    int n;
    ok = 1'b0;
    n = 0;
    rd(a, p);
    while (!ok && n < 1000) begin
      rd(a, v);
      ok = (v === p);
      p = v;
      n++;
    end
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the flash command and status logic.
// Assumes cpu_model drives the bus; the bench drives modes and event inputs.
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module tb_top
  import flash_cmd_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cpu_bus_t bus;
  logic parallel_mode = 1'b0, serial_mode = 1'b0, slow_mode = 1'b0;
  logic loader_entry = 1'b0, overwrite_req = 1'b0, loader_req = 1'b0;
  logic software_irq = 1'b0, undefined_instr_irq = 1'b0, watchdog_irq = 1'b0;
  logic [7:0] rd_data;
  logic busy, access_block, protected_out, overwrite_ok, loader_ok, irq_masked, clock_reset;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] v, w;
  logic ok;

  always #12.5 sys_clk = ~sys_clk;

  cpu_model u_cpu (.sys_clk(sys_clk), .rdata(rd_data), .bus(bus));

  flash_cmd_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .parallel_mode(parallel_mode), .serial_mode(serial_mode), .slow_mode(slow_mode),
    .loader_entry(loader_entry), .overwrite_req(overwrite_req), .loader_req(loader_req),
    .software_irq(software_irq), .undefined_instr_irq(undefined_instr_irq),
    .watchdog_irq(watchdog_irq), .rd_data(rd_data), .busy(busy),
    .access_block(access_block), .protected_out(protected_out),
    .overwrite_ok(overwrite_ok), .loader_ok(loader_ok), .irq_masked(irq_masked),
    .clock_reset(clock_reset));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic flags(input logic [7:0] exp);
    check({1'b0, busy, access_block, protected_out, overwrite_ok, loader_ok, irq_masked,
      clock_reset}, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check({7'h0, busy}, 8'h00);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    flags(8'h00);
    u_cpu.rd(`STATUS_ADDR, v);
    check(v, 8'h08);
    u_cpu.rd(`MODE_AREA_ADDR, v);
    check(v, `MODE_AREA_RESET);
    u_cpu.rd(16'h0FD4, v);
    check(v, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_program();
    u_cpu.cmd_on();
    u_cpu.cmd(`OP_PROGRAM);
    u_cpu.wr(16'hE500, 8'h3F);
    u_cpu.rd(16'hE500, v);
    check(v, 8'h40);
    u_cpu.rd(16'hE500, v);
    check(v, 8'h00);
    flags(8'h60);
    u_cpu.cmd_off();
    u_cpu.rd(16'hE500, v);
    u_cpu.rd(16'hE500, w);
    check(w, v);
    u_cpu.cmd_on();
    u_cpu.poll(16'hE500, v, ok);
    check({7'h0, ok}, 8'h01);
    check(v, 8'h3F);
    // Second key wrong: the rest must not launch anything
    u_cpu.wr(16'hF555, 8'hAA);
    u_cpu.wr(16'hFAAA, 8'h54);
    u_cpu.wr(16'hF555, 8'hA0);
    u_cpu.wr(16'hE600, 8'h12);
    @(posedge sys_clk);
    #1;
    flags(8'h00);
    $display("test program done");
  endtask

  task automatic t_slow();
    @(posedge sys_clk) slow_mode <= 1'b1;
    u_cpu.cmd(`OP_PROGRAM);
    u_cpu.wr(16'hE501, 8'h5A);
    u_cpu.rd(16'hE501, v);
    check(v, 8'h5A);
    @(posedge sys_clk) slow_mode <= 1'b0;
    $display("test slow done");
  endtask

  task automatic t_ident();
    u_cpu.cmd(`OP_ID_ENTRY);
    u_cpu.rd(`ID_VENDOR_ADDR, v);
    check(v, 8'h11);
    u_cpu.rd(`ID_FLASH_ADDR, v);
    check(v, 8'h22);
    u_cpu.rd(`SECURE_ADDR, v);
    check(v, 8'hFF);
    u_cpu.wr(16'hE500, `OP_ID_EXIT);
    u_cpu.rd(16'hE500, v);
    check(v, 8'h3F);
    $display("test ident done");
  endtask

  task automatic t_loader();
    @(posedge sys_clk) loader_entry <= 1'b1;
    @(posedge sys_clk) loader_entry <= 1'b0;
    u_cpu.rd(`SYS_CTRL_C_ADDR, v);
    check(v, 8'h03);
    flags(8'h02);
    // Vector bit never cleared, so NMI vectors stay in RAM
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) {software_irq, undefined_instr_irq, watchdog_irq} <= 3'b100 >> i;
      #1;
      flags(8'h03);
      @(posedge sys_clk) {software_irq, undefined_instr_irq, watchdog_irq} <= 3'b000;
      #1;
      flags(8'h02);
    end
    $display("test loader done");
  endtask

  task automatic t_secure();
    @(posedge sys_clk) {serial_mode, overwrite_req, loader_req} <= 3'b111;
    #1;
    flags(8'h0E);
    u_cpu.cmd(`OP_SECURE);
    u_cpu.wr(`SECURE_ADDR, 8'h00);
    u_cpu.rd(16'hE500, v);
    check(v, 8'h40);
    u_cpu.cmd(`OP_ID_ENTRY);
    wait_idle();
    u_cpu.rd(`ID_VENDOR_ADDR, v);
    check({7'h0, v === 8'h11}, 8'h00);
    flags(8'h12);
    u_cpu.cmd(`OP_ID_ENTRY);
    u_cpu.rd(`SECURE_ADDR, v);
    check(v, 8'h00);
    u_cpu.wr(16'hF000, `OP_ID_EXIT);
    @(posedge sys_clk) parallel_mode <= 1'b1;
    u_cpu.rd(16'hE500, v);
    check(v, 8'h00);
    u_cpu.cmd(`OP_PROGRAM);
    u_cpu.wr(16'hE502, 8'h77);
    // Sector erase is refused in parallel mode and must keep protection
    u_cpu.cmd(`OP_ERASE);
    u_cpu.wr(16'hF555, `KEY_FIRST);
    u_cpu.wr(16'hFAAA, `KEY_SECOND);
    u_cpu.wr(16'hE000, `OP_SECTOR);
    @(posedge sys_clk) parallel_mode <= 1'b0;
    #1;
    flags(8'h12);
    u_cpu.cmd(`OP_ERASE);
    u_cpu.cmd(`OP_CHIP);
    u_cpu.rd(16'hE500, v);
    check(v, 8'h40);
    flags(8'h6E);
    $display("test secure done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  // Run ends with the chip erase still running; no reset is applied then
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_program();
    t_slow();
    t_ident();
    t_loader();
    t_secure();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule
